// ==== core/scc_dither.sv ====
// scc_dither: symmetric triangle offset around the centre frequency.
// assumes a tick from the parent at the dither step rate.
`timescale 1ns/1ps
module scc_dither
    import scc_pkg::*;
#(
    parameter int AMP_W = 5
)
(
    input  wire logic             mclk_in,
    input  wire logic             nrst_in,
    input  wire logic             enable_in,
    input  wire logic             step_in,
    input  wire logic [1:0]       amount_in,
    output logic signed [AMP_W:0] offset_out
);
    typedef struct packed {
        logic signed [AMP_W:0] off;
        logic                  up;
    } scc_dith_t;

    scc_dith_t st_ff;
    scc_dith_t nxt_st;
    logic signed [AMP_W:0] lim;

    always_comb
    begin
        lim    = (AMP_W+1)'(signed'(6'sd1 <<< amount_in));
        nxt_st = st_ff;
        if (!enable_in)
        begin
            // return to centre when idle, no bias left behind
            nxt_st.off = '0;
            nxt_st.up  = 1'b1;
        end
        else if (step_in)
        begin
            // equal excursion up and down keeps the mean on centre
            if (st_ff.up)
            begin
                if (st_ff.off >= lim)
                begin
                    nxt_st.up  = 1'b0;
                    nxt_st.off = st_ff.off - (AMP_W+1)'(1);
                end
                else
                    nxt_st.off = st_ff.off + (AMP_W+1)'(1);
            end
            else
            begin
                if (st_ff.off <= -lim)
                begin
                    nxt_st.up  = 1'b1;
                    nxt_st.off = st_ff.off + (AMP_W+1)'(1);
                end
                else
                    nxt_st.off = st_ff.off - (AMP_W+1)'(1);
            end
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            st_ff <= '{off: '0, up: 1'b1};
        else
            st_ff <= nxt_st;
    end

    assign offset_out = st_ff.off;
endmodule

// ==== core/scc_pkg.sv ====
// scc_pkg: constants shared by the spread clock output control block.
// assumes a 200 MHz system clock standing in for the master oscillator.
package scc_pkg;
    localparam int          CLK_MHZ          = 200;
    localparam int          STAB_CYCLES      = 512;
    localparam int          PDN_DELAY_US     = 7;
    localparam int          PDN_DELAY_CYC    = PDN_DELAY_US * CLK_MHZ;
    localparam int          DEGLITCH_US      = 10;
    localparam int          DEGLITCH_CYC     = DEGLITCH_US * CLK_MHZ;
    localparam int          NV_WRITE_MIN_MS  = 10;
    localparam int          NV_WRITE_MAX_MS  = 20;
    localparam int          NV_WRITE_CYC     = NV_WRITE_MIN_MS * 1000 * CLK_MHZ;
    localparam int          SCL_MAX_KHZ      = 400;
    localparam int          DUTY_PCT         = 50;
    localparam int          DIV_W            = 4;
    localparam logic [3:0]  DIV_MAX_SEL      = 4'h8;
    localparam int          DITH_W           = 2;
    localparam int          CNT_W            = 24;
    localparam logic [1:0]  DITH_RATE_OFF    = 2'h0;
    localparam logic [2:0]  DITH_AMP_1       = 3'h1;

    typedef enum logic [3:0] {
        SCC_ST_OFF    = 4'b0001,
        SCC_ST_STAB   = 4'b0010,
        SCC_ST_RUN    = 4'b0100,
        SCC_ST_PDWAIT = 4'b1000
    } scc_state_t;
endpackage

// ==== core/scc_top.sv ====
// scc_top: output sequencing of a spread spectrum clock generator.
// assumes pins arrive asynchronously; config bits come from the serial port logic.
`timescale 1ns/1ps
// Contract
// - a new divider setting takes effect within one output period.
// - leaving power-down, the output stays off for 512 oscillator cycles then enables.
// - after power-up, the output waits 512 oscillator cycles before going active.
// - entering power-down disables the output about 7 us after the request.
// - the output clock has a 50 percent duty cycle at every divider setting.
// - the serial port handles fast and standard mode, at most 400 kHz.
// - the nonvolatile write starts at the stop condition and ends within 10 to 20 ms.
// - with write control 0, all nonvolatile memory is committed automatically.
// - dither pin high dithers the oscillator, low gives a clean clock.
// - output enable high drives the output; low disables it while the oscillator runs, unless oe_bit_n_in is 0.
// - power-down pin high runs the oscillator, low stops it and disables the output.
// - dither goes equally up and down so the mean stays at centre.
// - output enabling is synchronous and glitch free; its latency varies with the output phase.
// - with write control 0, each register write triggers a nonvolatile write.
module scc_top
    import scc_pkg::*;
#(
    parameter int STAB_N   = STAB_CYCLES,
    parameter int PDN_N    = PDN_DELAY_CYC,
    parameter int NVWR_N   = NV_WRITE_CYC,
    parameter int DITH_AMP = 5
)
(
    input  wire logic              mclk_in,
    input  wire logic              nrst_in,
    input  wire logic              dither_enable_pin_in,
    input  wire logic              output_enable_pin_in,
    input  wire logic              power_down_pin_in,
    input  wire logic [scc_pkg::DIV_W-1:0] div_sel_in,
    input  wire logic [1:0]        dith_rate_in,
    input  wire logic [1:0]        dith_amount_in,
    input  wire logic              oe_bit_n_in,
    input  wire logic              out_low_in,
    input  wire logic              nv_write_control_bit_in,
    input  wire logic              reg_write_in,
    input  wire logic              i2c_stop_in,
    input  wire logic              write_ee_cmd_in,
    output logic                   clk_out,
    output logic                   clk_oe_n_out,
    output logic                   osc_run_out,
    output logic signed [DITH_AMP:0] dither_offset_out,
    output logic                   nv_busy_out,
    output logic                   nv_commit_out,
    output logic                   out_active_out
);
    import scc_pkg::*;

    typedef struct packed {
        logic [1:0]       spr_sy;
        logic [1:0]       oe_sy;
        logic [1:0]       pd_sy;
        scc_state_t       state;
        logic [CNT_W-1:0] cnt;
        logic [8:0]       div_cnt;
        logic [DIV_W-1:0] div_act;
        logic             clk;
        logic             gate;
        logic             nv_pend;
        logic             nv_busy;
        logic [CNT_W-1:0] nv_cnt;
        logic             commit;
        logic [12:0]      dstep;
    } scc_st_t;

    scc_st_t st_ff;
    scc_st_t nxt_st;

    logic             spr_s;
    logic             oe_s;
    logic             pd_s;
    logic [3:0]       div_clip;
    logic [8:0]       half_last;
    logic             half_end;
    logic             want_out;
    logic             dith_en;
    logic             dith_step;
    logic [12:0]      step_mask;

    assign spr_s = st_ff.spr_sy[1];
    assign oe_s  = st_ff.oe_sy[1];
    assign pd_s  = st_ff.pd_sy[1];

    // settings above 8 clamp to 2^8
    assign div_clip  = (div_sel_in > DIV_MAX_SEL) ? DIV_MAX_SEL : div_sel_in;
    // period of 2^x cycles; x=0 toggles every cycle like x=1, halving the oscillator
    assign half_last = (st_ff.div_act == 4'h0) ? 9'h000
                     : 9'((10'h001 << st_ff.div_act) >> 1) - 9'h001;
    assign half_end  = (st_ff.div_cnt >= half_last);

    // pin or register bit; power is left to the sequencer so a short drop keeps the output
    assign want_out  = oe_s | ~oe_bit_n_in;

    assign dith_en   = spr_s & (dith_rate_in != DITH_RATE_OFF);
    always_comb
    begin
        unique case (dith_rate_in)
            2'h1:    step_mask = 13'h00ff;
            2'h2:    step_mask = 13'h01ff;
            default: step_mask = 13'h03ff;
        endcase
    end
    assign dith_step = dith_en && ((st_ff.dstep & step_mask) == 13'h0000);

    always_comb
    begin
        nxt_st        = st_ff;
        nxt_st.spr_sy = {st_ff.spr_sy[0], dither_enable_pin_in};
        nxt_st.oe_sy  = {st_ff.oe_sy[0], output_enable_pin_in};
        nxt_st.pd_sy  = {st_ff.pd_sy[0], power_down_pin_in};
        nxt_st.commit = 1'b0;
        nxt_st.dstep  = dith_en ? st_ff.dstep + 13'h0001 : 13'h0000;

        // divider: toggles on each half period end
        if (st_ff.state == SCC_ST_OFF || st_ff.state == SCC_ST_STAB)
        begin
            nxt_st.div_cnt = '0;
            nxt_st.clk     = 1'b0;
            nxt_st.div_act = div_clip;
        end
        else if (half_end)
        begin
            nxt_st.div_cnt = '0;
            nxt_st.clk     = ~st_ff.clk;
            // new divide picked up at a period boundary, so it settles in one period
            if (st_ff.clk)
                nxt_st.div_act = div_clip;
        end
        else
            nxt_st.div_cnt = st_ff.div_cnt + 9'h001;

        // gate changes at the low phase end, so no runt pulse; entering off closes it at once
        if (st_ff.state == SCC_ST_RUN || st_ff.state == SCC_ST_PDWAIT)
        begin
            if (!st_ff.clk && half_end)
                nxt_st.gate = want_out;
        end
        else
            nxt_st.gate = 1'b0;

        unique case (st_ff.state)
            SCC_ST_OFF:
            begin
                nxt_st.cnt = '0;
                if (pd_s)
                    nxt_st.state = SCC_ST_STAB;
            end
            SCC_ST_STAB:
            begin
                // 512 oscillator cycles before the output may go active
                if (!pd_s)
                begin
                    nxt_st.state = SCC_ST_OFF;
                    nxt_st.cnt   = '0;
                end
                else if (st_ff.cnt >= CNT_W'(STAB_N - 1))
                begin
                    nxt_st.state = SCC_ST_RUN;
                    nxt_st.cnt   = '0;
                end
                else
                    nxt_st.cnt = st_ff.cnt + CNT_W'(1);
            end
            SCC_ST_RUN:
            begin
                nxt_st.cnt = '0;
                if (!pd_s)
                    nxt_st.state = SCC_ST_PDWAIT;
            end
            SCC_ST_PDWAIT:
            begin
                // request must stand for the whole delay; a short glitch is ignored
                if (pd_s)
                begin
                    nxt_st.state = SCC_ST_RUN;
                    nxt_st.cnt   = '0;
                end
                else if (st_ff.cnt >= CNT_W'(PDN_N - 1))
                begin
                    nxt_st.state = SCC_ST_OFF;
                    nxt_st.cnt   = '0;
                    nxt_st.gate  = 1'b0;
                end
                else
                    nxt_st.cnt = st_ff.cnt + CNT_W'(1);
            end
            default:
            begin
                nxt_st.state = SCC_ST_OFF;
                nxt_st.cnt   = '0;
            end
        endcase

        // auto commit on writes when write control is 0, explicit command otherwise
        if (reg_write_in && !nv_write_control_bit_in)
            nxt_st.nv_pend = 1'b1;
        if (write_ee_cmd_in)
            nxt_st.nv_pend = 1'b1;
        // programming starts at stop and runs the minimum write time
        if (i2c_stop_in && st_ff.nv_pend && !st_ff.nv_busy)
        begin
            nxt_st.nv_busy = 1'b1;
            nxt_st.nv_cnt  = '0;
            nxt_st.nv_pend = (reg_write_in & ~nv_write_control_bit_in) | write_ee_cmd_in;
        end
        else if (st_ff.nv_busy)
        begin
            if (st_ff.nv_cnt >= CNT_W'(NVWR_N - 1))
            begin
                nxt_st.nv_busy = 1'b0;
                nxt_st.commit  = 1'b1;
            end
            else
                nxt_st.nv_cnt = st_ff.nv_cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            st_ff <= '{state: SCC_ST_OFF, default: '0};
        else
            st_ff <= nxt_st;
    end

    scc_dither #(
        .AMP_W (DITH_AMP)
    ) u_dither (
        .mclk_in    (mclk_in),
        .nrst_in    (nrst_in),
        .enable_in  (dith_en),
        .step_in    (dith_step),
        .amount_in  (dith_amount_in),
        .offset_out (dither_offset_out)
    );

    // serial timing at up to 400 kHz is the port logic's duty; no check here
    assign clk_out        = st_ff.clk & st_ff.gate;
    // driven low when disabled and low mode chosen, else released
    assign clk_oe_n_out   = ~(st_ff.gate | out_low_in);
    assign osc_run_out    = (st_ff.state != SCC_ST_OFF);
    assign nv_busy_out    = st_ff.nv_busy;
    assign nv_commit_out  = st_ff.commit;
    assign out_active_out = st_ff.gate;
endmodule

// ==== tb/scc_clk_sink.sv ====
// scc_clk_sink: downstream consumer that measures the generated clock halves.
// assumes the clock under test changes only just after mclk edges.
`timescale 1ns/1ps
module scc_clk_sink
(
    input  wire logic  mclk_in,
    input  wire logic  clk_in,
    output logic [9:0] hi_len_out,
    output logic [9:0] lo_len_out
);
    logic [9:0] run_ff  = 10'h000;
    logic       last_ff = 1'b0;
    initial hi_len_out = 10'h000;
    initial lo_len_out = 10'h000;
    always @(posedge mclk_in)
    begin
        last_ff <= clk_in;
        if (clk_in != last_ff)
        begin
            if (last_ff)
                hi_len_out <= run_ff;
            else
                lo_len_out <= run_ff;
            run_ff <= 10'h001;
        end
        else
            run_ff <= run_ff + 10'h001;
    end
endmodule

// ==== tb/scc_top_properties.sv ====
// scc_top_chk: port-level assertions on scc_top.
// assumes the bind below hands on the count parameters of the instance.
`timescale 1ns/1ps
module scc_top_chk
    import scc_pkg::*;
#(
    parameter int STAB_N   = STAB_CYCLES,
    parameter int NVWR_N   = NV_WRITE_CYC,
    parameter int DITH_AMP = 5
)
(
    input wire logic                 mclk_in,
    input wire logic                 nrst_in,
    input wire logic                 dither_enable_pin_in,
    input wire logic                 nv_write_control_bit_in,
    input wire logic                 reg_write_in,
    input wire logic                 i2c_stop_in,
    input wire logic                 clk_out,
    input wire logic                 clk_oe_n_out,
    input wire logic                 osc_run_out,
    input wire logic signed [DITH_AMP:0] dither_offset_out,
    input wire logic                 nv_busy_out,
    input wire logic                 nv_commit_out,
    input wire logic                 out_active_out
);
    localparam int CMIN = NVWR_N - 2;
    localparam int CMAX = NVWR_N + 2;
    logic [9:0] run_cnt_ff;
    logic [CNT_W-1:0] busy_cnt_ff;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    // saturates so a long run never wraps back under the threshold
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            run_cnt_ff  <= 10'h000;
            busy_cnt_ff <= '0;
        end
        else
        begin
            run_cnt_ff  <= osc_run_out ? run_cnt_ff + {9'h000, ~&run_cnt_ff} : 10'h000;
            // counter instead of a delay range: the real write time is millions of cycles
            busy_cnt_ff <= nv_busy_out ? busy_cnt_ff + CNT_W'(1) : '0;
        end
    end
    sequence s_auto_write;
        reg_write_in && !nv_write_control_bit_in && !nv_busy_out;
    endsequence
    sequence s_free_stop;
        i2c_stop_in && !nv_busy_out;
    endsequence
    chk_active_needs_run: assert property (out_active_out |-> osc_run_out)
        else $error("output active while oscillator stopped");
    chk_active_drives_pad: assert property (out_active_out |-> !clk_oe_n_out)
        else $error("output active but pad not driven");
    chk_stab_count: assert property ($rose(out_active_out) |-> run_cnt_ff >= STAB_N)
        else $error("output enabled before stabilisation count");
    chk_gate_sync: assert property ($rose(out_active_out) |-> clk_out)
        else $error("gate opened outside low half");
    chk_busy_cause: assert property ($rose(nv_busy_out) |-> $past(i2c_stop_in))
        else $error("write started without stop");
    chk_commit_time: assert property ($fell(nv_busy_out) |-> nv_commit_out
        && busy_cnt_ff >= CMIN && busy_cnt_ff <= CMAX)
        else $error("commit outside write time");
    chk_auto_commit: assert property (s_auto_write ##[1:8] s_free_stop |-> ##1 nv_busy_out)
        else $error("register write not committed");
    chk_dither_off: assert property (!dither_enable_pin_in [*6] |-> dither_offset_out == 0)
        else $error("offset present with dither off");
endmodule

bind scc_top scc_top_chk #(.STAB_N(STAB_N), .NVWR_N(NVWR_N), .DITH_AMP(DITH_AMP)) u_chk (
    .mclk_in, .nrst_in, .dither_enable_pin_in, .nv_write_control_bit_in, .reg_write_in,
    .i2c_stop_in, .clk_out, .clk_oe_n_out, .osc_run_out, .dither_offset_out, .nv_busy_out,
    .nv_commit_out, .out_active_out);

// ==== tb/test_spread_clock_output_control.sv ====
// test_spread_clock_output_control: directed bench for scc_top.
// assumes shortened counts; pins driven by nonblocking writes at rising edges.
`timescale 1ns/1ps
module test_spread_clock_output_control;
    import scc_pkg::*;
    localparam int SN = 16;
    localparam int PN = 20;
    localparam int NN = 50;
    logic mclk_in = 1'b0, nrst_in = 1'b0, dither_enable_pin_in = 1'b0;
    logic output_enable_pin_in = 1'b1, power_down_pin_in = 1'b0, oe_bit_n_in = 1'b1;
    logic out_low_in = 1'b1, nv_write_control_bit_in = 1'b0, reg_write_in = 1'b0;
    logic i2c_stop_in = 1'b0, write_ee_cmd_in = 1'b0;
    logic [DIV_W-1:0] div_sel_in = 4'h1;
    logic [1:0] dith_rate_in = 2'h0, dith_amount_in = 2'h0;
    logic clk_out, clk_oe_n_out, osc_run_out, nv_busy_out, nv_commit_out, out_active_out;
    logic signed [5:0] dither_offset_out, mx, mn;
    logic [9:0] hi_len, lo_len, per[4];
    int num_errors = 0;
    int tests_run = 0;
    int n;
    always #2.5 mclk_in = ~mclk_in;
    scc_top #(.STAB_N(SN), .PDN_N(PN), .NVWR_N(NN), .DITH_AMP(5)) i_dut (
        .mclk_in, .nrst_in, .dither_enable_pin_in, .output_enable_pin_in, .power_down_pin_in,
        .div_sel_in, .dith_rate_in, .dith_amount_in, .oe_bit_n_in, .out_low_in,
        .nv_write_control_bit_in, .reg_write_in, .i2c_stop_in, .write_ee_cmd_in, .clk_out,
        .clk_oe_n_out, .osc_run_out, .dither_offset_out, .nv_busy_out, .nv_commit_out,
        .out_active_out);
    scc_clk_sink u_sink (.mclk_in(mclk_in), .clk_in(clk_out), .hi_len_out(hi_len),
        .lo_len_out(lo_len));
    task automatic summarize();
        if (num_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic sel(input int w);
        case (w)
            0: sel = out_active_out;
            1: sel = osc_run_out;
            2: sel = nv_busy_out;
            default: sel = nv_commit_out;
        endcase
    endfunction
    // bounded wait; a timeout ends the run as a failure
    task automatic wait_sig(input int w, input logic want, output int cnt);
        for (cnt = 1; cnt < 4000; cnt++)
        begin
            @(posedge mclk_in);
            #1;
            if (sel(w) === want)
                return;
        end
        num_errors++;
        summarize();
    endtask
    task automatic pulse(input int w);
        @(posedge mclk_in);
        reg_write_in <= (w == 0);
        i2c_stop_in <= (w == 1);
        write_ee_cmd_in <= (w == 2);
        @(posedge mclk_in);
        {reg_write_in, i2c_stop_in, write_ee_cmd_in} <= 3'h0;
    endtask
    task automatic pd_set(input logic v);
        @(posedge mclk_in);
        power_down_pin_in <= v;
    endtask
    initial
    begin
        repeat (12) @(posedge mclk_in);
        check(clk_oe_n_out, 1'b0);
        nrst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        pd_set(1'b1);
        wait_sig(0, 1'b1, n);
        check(n >= SN + 2 && n <= SN + 20, 1'b1);
        for (int d = 1; d < 4; d++)
        begin
            div_sel_in <= d[3:0];
            // one old period to pick up, one new period, one sink cycle: well inside this
            repeat (3 << d) @(posedge mclk_in);
            check(hi_len, lo_len);
            per[d] = hi_len + lo_len;
            if (d > 1)
                check(per[d], 2 * per[d-1]);
        end
        output_enable_pin_in <= 1'b0;
        wait_sig(0, 1'b0, n);
        check(osc_run_out, 1'b1);
        check(clk_oe_n_out, 1'b0);
        out_low_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        check(clk_oe_n_out, 1'b1);
        oe_bit_n_in <= 1'b0;
        wait_sig(0, 1'b1, n);
        check(n <= 20, 1'b1);
        // a drop shorter than the power-down delay must be ignored
        pd_set(1'b0);
        repeat (PN / 2) @(posedge mclk_in);
        pd_set(1'b1);
        check(out_active_out, 1'b1);
        repeat (PN + 10) @(posedge mclk_in);
        check(osc_run_out, 1'b1);
        pd_set(1'b0);
        wait_sig(1, 1'b0, n);
        check(n >= PN + 1 && n <= PN + 6, 1'b1);
        check(out_active_out, 1'b0);
        pd_set(1'b1);
        wait_sig(0, 1'b1, n);
        check(n >= SN + 2 && n <= SN + 20, 1'b1);
        dith_rate_in <= 2'h1;
        dither_enable_pin_in <= 1'b1;
        mx = 6'sh00;
        mn = 6'sh00;
        repeat (3000)
        begin
            @(posedge mclk_in);
            if (dither_offset_out > mx)
                mx = dither_offset_out;
            if (dither_offset_out < mn)
                mn = dither_offset_out;
        end
        check(mx != 0, 1'b1);
        check(32'(mx), 32'(-mn));
        dither_enable_pin_in <= 1'b0;
        pulse(0);
        pulse(1);
        wait_sig(2, 1'b1, n);
        check(n <= 2, 1'b1);
        wait_sig(3, 1'b1, n);
        check(n >= NN - 2 && n <= NN + 2, 1'b1);
        pulse(1);
        repeat (3) @(posedge mclk_in);
        check(nv_busy_out, 1'b0);
        nv_write_control_bit_in <= 1'b1;
        pulse(0);
        pulse(1);
        repeat (3) @(posedge mclk_in);
        check(nv_busy_out, 1'b0);
        pulse(2);
        pulse(1);
        wait_sig(2, 1'b1, n);
        check(n <= 2, 1'b1);
        wait_sig(3, 1'b1, n);
        check(n >= NN - 2 && n <= NN + 2, 1'b1);
        summarize();
    end
endmodule
